/* File: shared/hotplug_cfg.svh */
`ifndef HOTPLUG_CFG_SVH
`define HOTPLUG_CFG_SVH

// apb register byte offsets
`define REG_CTRL_OFF      12'h000
`define REG_STATUS_OFF    12'h004
`define REG_CMD_OFF       12'h008
`define REG_EVENT_OFF     12'h00c

// control register fields
`define CTRL_DUAL_BIT     0
`define CTRL_AUX_BLK0_BIT 1
`define CTRL_AUX_BLK1_BIT 2
`define CTRL_RESET_VAL    32'h0000_0000

// command register fields: per slot, insert at bit s, remove at bit 4+s
`define CMD_INSERT_LSB    0
`define CMD_REMOVE_LSB    4

// sequencing times in ns at 25 MHz
`define CLK_PERIOD_NS     40
`define PWR_SETTLE_NS     100000
`define PWR_SETTLE_CYC    ((`PWR_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CLK_RUN_NS        4000
`define CLK_RUN_CYC       ((`CLK_RUN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: shared/hotplug_pkg.sv */
package hotplug_pkg;

    typedef enum logic [3:0] {
        ST_OFF,
        ST_PWR_ON,
        ST_PWR_WAIT,
        ST_CONNECT,
        ST_CLK_RUN,
        ST_ON,
        ST_RST_ON,
        ST_DISCONNECT,
        ST_PWR_OFF,
        ST_FAULT
    } slot_state_type;

    typedef struct packed {
        logic pwr_en;
        logic bus_iso_en;
        logic clk_iso_en;
        logic reset_n;
        logic busy;
        logic green;
        logic amber;
    } slot_ctl_type;

    typedef struct packed {
        logic fault;
        logic latch_open;
        logic attn;
    } slot_in_type;

endpackage : hotplug_pkg

/* File: src/slot_sequencer.sv */
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "hotplug_cfg.svh"

module slot_sequencer
    import hotplug_pkg::*;
#(
    parameter int unsigned SETTLE_CYC = `PWR_SETTLE_CYC,
    parameter int unsigned RUN_CYC    = `CLK_RUN_CYC
)(
    input  wire logic         clk_sys,
    input  wire logic         reset_n,
    input  wire logic         insert_req,
    input  wire logic         remove_req,
    input  wire slot_in_type  pins,
    output slot_ctl_type      ctl,
    output slot_state_type    state,
    output logic              fault_evt
);
    slot_state_type state_ff, nxt_state;
    logic [31:0]    cnt_ff, nxt_cnt;
    logic           attn_d_ff, nxt_attn_d;
    logic           attn_press;

    assign attn_press = pins.attn & ~attn_d_ff;
    assign state      = state_ff;

    always_comb
    begin
        nxt_state  = state_ff;
        nxt_cnt    = (cnt_ff == 32'h0) ? 32'h0 : cnt_ff - 32'h1;
        nxt_attn_d = pins.attn;
        fault_evt  = 1'b0;
        case (state_ff)
            ST_OFF:
            begin
                // attention press or software asks to bring the slot up
                if ((insert_req | attn_press) & ~pins.latch_open)
                begin
                    nxt_state = ST_PWR_ON;
                end
            end
            ST_PWR_ON:
            begin
                nxt_state = ST_PWR_WAIT;
                nxt_cnt   = SETTLE_CYC;
            end
            ST_PWR_WAIT:
            begin
                if (cnt_ff == 32'h0)
                begin
                    nxt_state = ST_CONNECT; // power good before bus joins
                end
            end
            ST_CONNECT:
            begin
                nxt_state = ST_CLK_RUN;
                nxt_cnt   = RUN_CYC;
            end
            ST_CLK_RUN:
            begin
                if (cnt_ff == 32'h0)
                begin
                    nxt_state = ST_ON; // bus joined before reset leaves
                end
            end
            ST_ON:
            begin
                if (remove_req | attn_press | pins.latch_open)
                begin
                    nxt_state = ST_RST_ON;
                end
            end
            ST_RST_ON:
            begin
                nxt_state = ST_DISCONNECT;
                nxt_cnt   = RUN_CYC;
            end
            ST_DISCONNECT:
            begin
                if (cnt_ff == 32'h0)
                begin
                    nxt_state = ST_PWR_OFF;
                end
            end
            ST_PWR_OFF:
            begin
                nxt_state = ST_OFF;
            end
            ST_FAULT:
            begin
                if (pins.latch_open & ~pins.fault)
                begin
                    nxt_state = ST_OFF;
                end
            end
            default:
            begin
                nxt_state = ST_OFF;
            end
        endcase
        // a power fault overrides any powered state
        if (pins.fault && state_ff != ST_OFF && state_ff != ST_FAULT)
        begin
            nxt_state = ST_FAULT;
            fault_evt = 1'b1;
        end
    end

    always_comb
    begin
        ctl         = '0;
        ctl.reset_n = 1'b0;
        case (state_ff)
            // on removal the bus opens while power still stands
            ST_PWR_ON, ST_PWR_WAIT, ST_DISCONNECT:
            begin
                ctl.pwr_en = 1'b1;
                ctl.busy   = 1'b1;
            end
            ST_CONNECT, ST_CLK_RUN, ST_RST_ON:
            begin
                ctl.pwr_en     = 1'b1;
                ctl.bus_iso_en = 1'b1;
                ctl.clk_iso_en = 1'b1;
                ctl.busy       = 1'b1;
            end
            ST_ON:
            begin
                ctl.pwr_en     = 1'b1;
                ctl.bus_iso_en = 1'b1;
                ctl.clk_iso_en = 1'b1;
                ctl.reset_n    = 1'b1;
            end
            ST_FAULT:
            begin
                ctl.amber = 1'b1;
            end
            default:
            begin
                ctl = ctl;
            end
        endcase
        ctl.green = ctl.pwr_en;
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_ff  <= ST_OFF;
            cnt_ff    <= 32'h0;
            attn_d_ff <= 1'b0;
        end
        else
        begin
            state_ff  <= nxt_state;
            cnt_ff    <= nxt_cnt;
            attn_d_ff <= nxt_attn_d;
        end
    end

    a_reset_after_bus : assert property (@(posedge clk_sys) disable iff (!reset_n)
        ctl.reset_n |-> (ctl.bus_iso_en && ctl.clk_iso_en && ctl.pwr_en))
        else $error("slot reset released before bus joined");
    a_fault_to_off : assert property (@(posedge clk_sys) disable iff (!reset_n)
        (pins.fault && state_ff == ST_ON) |=> (state_ff == ST_FAULT && !ctl.pwr_en))
        else $error("fault did not shut slot down");
    a_power_settles : assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_ff == ST_PWR_ON && !pins.fault) |=> !ctl.bus_iso_en [*2])
        else $error("bus joined before power settled");
endmodule : slot_sequencer

/* File: src/apb_regs.sv */
`timescale 1ns/100ps
`include "hotplug_cfg.svh"

module apb_regs
    import hotplug_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] status,
    input  wire logic [1:0]  fault_evt,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      ctrl,
    output logic [7:0]       cmd_pulse
);
    logic [31:0] ctrl_ff, nxt_ctrl;
    logic [31:0] prdata_ff, nxt_prdata;
    logic        pslverr_ff, nxt_pslverr;
    logic        pready_ff, nxt_pready;
    logic [7:0]  cmd_ff, nxt_cmd;
    logic [1:0]  evt_ff, nxt_evt;
    logic        acc;

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == `REG_CTRL_OFF) || (a == `REG_STATUS_OFF) ||
                 (a == `REG_CMD_OFF) || (a == `REG_EVENT_OFF);
    endfunction : mapped

    assign acc       = psel & penable;
    assign prdata    = prdata_ff;
    assign pready    = pready_ff;
    assign pslverr   = pslverr_ff;
    assign ctrl      = ctrl_ff;
    assign cmd_pulse = cmd_ff;

    always_comb
    begin
        nxt_ctrl    = ctrl_ff;
        nxt_cmd     = 8'h00;
        nxt_prdata  = prdata_ff;
        nxt_pslverr = 1'b0;
        // zero wait states once out of reset
        nxt_pready  = 1'b1;
        // fault set wins over a clear in the same cycle
        nxt_evt     = evt_ff;
        if (psel && !penable)
        begin
            nxt_pslverr = ~mapped(paddr);
            case (paddr)
                `REG_CTRL_OFF:   nxt_prdata = ctrl_ff;
                `REG_STATUS_OFF: nxt_prdata = status;
                `REG_EVENT_OFF:  nxt_prdata = {30'h0, evt_ff};
                default:         nxt_prdata = 32'h0;
            endcase
        end
        if (acc && pwrite)
        begin
            case (paddr)
                `REG_CTRL_OFF:  nxt_ctrl = pwdata;
                `REG_CMD_OFF:   nxt_cmd  = pwdata[7:0];
                `REG_EVENT_OFF: nxt_evt  = evt_ff & ~pwdata[1:0];
                default:        nxt_ctrl = ctrl_ff;
            endcase
        end
        nxt_evt = nxt_evt | fault_evt;
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_ff    <= `CTRL_RESET_VAL;
            cmd_ff     <= 8'h00;
            prdata_ff  <= 32'h0;
            pslverr_ff <= 1'b0;
            pready_ff  <= 1'b0;
            evt_ff     <= 2'h0;
        end
        else
        begin
            ctrl_ff    <= nxt_ctrl;
            cmd_ff     <= nxt_cmd;
            prdata_ff  <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
            pready_ff  <= nxt_pready;
            evt_ff     <= nxt_evt;
        end
    end
endmodule : apb_regs

/* File: src/pci_hotplug_slot_control.sv */
`timescale 1ns/100ps
`include "hotplug_cfg.svh"

module pci_hotplug_slot_control
    import hotplug_pkg::*;
#(
    parameter int unsigned SETTLE_CYC = `PWR_SETTLE_CYC,
    parameter int unsigned RUN_CYC    = `CLK_RUN_CYC
)(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [1:0]  slot_power_fault_out_n,
    input  wire logic [1:0]  retention_latch_switch,
    input  wire logic [1:0]  attn_switch,
    output logic [1:0]       slot_pwr_en_ff,
    output logic [1:0]       bus_iso_en_ff,
    output logic [1:0]       clk_iso_en_ff,
    output logic [1:0]       slot_reset_n_ff,
    output logic [1:0]       aux_standby_rail_en_ff,
    output logic [1:0]       green_led_ff,
    output logic [1:0]       amber_led_ff,
    output logic             bus_quiesce_ff,
    output logic             slot_clk_gate_ff,
    output logic             fbk_clk_gate_ff
);
    slot_in_type    pins     [2];
    slot_ctl_type   ctl      [2];
    slot_state_type st       [2];
    logic [1:0]     fault_evt;
    logic [31:0]    ctrl;
    logic [7:0]     cmd;
    logic           dual;
    logic [31:0]    status;

    assign dual = ctrl[`CTRL_DUAL_BIT];

    genvar s;
    generate
        for (s = 0; s < 2; s++)
        begin : g_slot
            assign pins[s].fault      = ~slot_power_fault_out_n[s];
            assign pins[s].latch_open = retention_latch_switch[s];
            assign pins[s].attn       = attn_switch[s];

            // slot 1 ignores the software insert command in single-slot mode; its attention switch can still start it
            slot_sequencer #(
                .SETTLE_CYC (SETTLE_CYC),
                .RUN_CYC    (RUN_CYC)
            ) u_seq (
                .clk_sys    (clk_sys),
                .reset_n    (reset_n),
                .insert_req (cmd[`CMD_INSERT_LSB + s] & (dual | (s == 0))),
                .remove_req (cmd[`CMD_REMOVE_LSB + s]),
                .pins       (pins[s]),
                .ctl        (ctl[s]),
                .state      (st[s]),
                .fault_evt  (fault_evt[s])
            );
            assign status[8*s +: 8] = {ctl[s].reset_n, ctl[s].pwr_en, pins[s].fault,
                                       pins[s].latch_open, 4'(st[s])};
        end
    endgenerate
    assign status[31:16] = 16'h0;

    apb_regs u_regs (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .status    (status),
        .fault_evt (fault_evt),
        .prdata    (prdata),
        .pready    (pready),
        .pslverr   (pslverr),
        .ctrl      (ctrl),
        .cmd_pulse (cmd)
    );

    logic [1:0] nxt_pwr, nxt_bus, nxt_clk, nxt_rst, nxt_aux, nxt_grn, nxt_amb;
    logic       nxt_quiesce, nxt_slot_clk;
    logic [1:0] aux_block;

    assign aux_block = {ctrl[`CTRL_AUX_BLK1_BIT], ctrl[`CTRL_AUX_BLK0_BIT]};

    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            // discrete per-slot controls
            nxt_pwr[i] = ctl[i].pwr_en;
            nxt_bus[i] = ctl[i].bus_iso_en & dual;
            // dual mode gates clock through switch
            nxt_clk[i] = ctl[i].clk_iso_en & dual;
            nxt_rst[i] = ctl[i].reset_n;
            // standby enable follows closed latch unless blocked
            nxt_aux[i] = ~retention_latch_switch[i] & ~aux_block[i];
            nxt_grn[i] = ctl[i].green;
            nxt_amb[i] = ctl[i].amber | (ctl[i].busy & attn_switch[i]);
        end
        // single mode: bus low and slot clock held until the slot is joined
        nxt_quiesce  = ~dual & ~ctl[0].bus_iso_en;
        nxt_slot_clk = dual | ctl[0].clk_iso_en;
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            slot_pwr_en_ff         <= 2'h0;
            bus_iso_en_ff          <= 2'h0;
            clk_iso_en_ff          <= 2'h0;
            slot_reset_n_ff        <= 2'h0;
            aux_standby_rail_en_ff <= 2'h0;
            green_led_ff           <= 2'h0;
            amber_led_ff           <= 2'h0;
            bus_quiesce_ff         <= 1'b1;
            slot_clk_gate_ff       <= 1'b0;
            fbk_clk_gate_ff        <= 1'b0;
        end
        else
        begin
            slot_pwr_en_ff         <= nxt_pwr;
            bus_iso_en_ff          <= nxt_bus;
            clk_iso_en_ff          <= nxt_clk;
            slot_reset_n_ff        <= nxt_rst;
            aux_standby_rail_en_ff <= nxt_aux;
            green_led_ff           <= nxt_grn;
            amber_led_ff           <= nxt_amb;
            bus_quiesce_ff         <= nxt_quiesce;
            slot_clk_gate_ff       <= nxt_slot_clk;
            fbk_clk_gate_ff        <= 1'b1; // feedback clock stopped only while reset is held
        end
    end

    a_single_quiesce : assert property (@(posedge clk_sys) disable iff (!reset_n)
        (!dual && st[0] inside {ST_OFF, ST_PWR_ON, ST_PWR_WAIT, ST_DISCONNECT, ST_PWR_OFF, ST_FAULT})
        |=> (bus_quiesce_ff && !slot_clk_gate_ff))
        else $error("single-slot bus or clock not held");
    a_fbk_runs : assert property (@(posedge clk_sys) disable iff (!reset_n)
        !slot_clk_gate_ff |-> ##1 fbk_clk_gate_ff)
        else $error("feedback clock stopped");
    a_dual_clk_switch : assert property (@(posedge clk_sys) disable iff (!reset_n)
        dual [*2] |-> slot_clk_gate_ff)
        else $error("dual mode drove slot clock low");
    a_reset_order : assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(slot_reset_n_ff[0]) |-> slot_pwr_en_ff[0] && (dual ? bus_iso_en_ff[0] : !bus_quiesce_ff))
        else $error("reset released before connect");
    a_aux_follows : assert property (@(posedge clk_sys) disable iff (!reset_n)
        retention_latch_switch[1] |=> !aux_standby_rail_en_ff[1])
        else $error("standby enable with latch open");
endmodule : pci_hotplug_slot_control

/* File: sim/slot_power_model.sv */
`timescale 1ns/100ps

module slot_power_model
(
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic [1:0] pwr_en,
    input  wire logic [1:0] fault_cmd,
    output logic [1:0]      fault_n,
    output logic [1:0]      rails_on,
    output logic [1:0]      bias_on
);
    logic [1:0] trip_ff;

    // a tripped slot stays off until its enable is withdrawn
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            trip_ff  <= 2'h0;
            rails_on <= 2'h0;
        end
        else
        begin
            trip_ff  <= pwr_en & (trip_ff | (fault_cmd & rails_on));
            rails_on <= pwr_en & ~trip_ff & ~(fault_cmd & rails_on);
        end
    end

    assign fault_n = ~trip_ff;
    assign bias_on = rails_on;
endmodule : slot_power_model

/* File: sim/test_pci_hotplug_slot_control.sv */
`timescale 1ns/100ps
`include "hotplug_cfg.svh"

module test_pci_hotplug_slot_control
    import hotplug_pkg::*;
;
    localparam int SETTLE = 4;
    localparam int RUN    = 3;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        err;
    logic [1:0]  latch = 2'h0;
    logic [1:0]  attn  = 2'h0;
    logic [1:0]  fcmd  = 2'h0;
    logic [1:0]  fault_n, pwr_en, bus_iso, clk_iso, rst_n, aux, green, amber, rails, bias;
    logic        quiesce, slot_clk, fbk_clk;
    int          n_errors  = 0;
    int          cmp_count = 0;

    always #20 clk_sys = ~clk_sys;

    pci_hotplug_slot_control #(.SETTLE_CYC(SETTLE), .RUN_CYC(RUN)) dut_u (
        .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .slot_power_fault_out_n(fault_n), .retention_latch_switch(latch), .attn_switch(attn),
        .slot_pwr_en_ff(pwr_en), .bus_iso_en_ff(bus_iso), .clk_iso_en_ff(clk_iso),
        .slot_reset_n_ff(rst_n), .aux_standby_rail_en_ff(aux), .green_led_ff(green),
        .amber_led_ff(amber), .bus_quiesce_ff(quiesce), .slot_clk_gate_ff(slot_clk),
        .fbk_clk_gate_ff(fbk_clk));

    slot_power_model pwr_u (
        .clk_sys(clk_sys), .reset_n(reset_n), .pwr_en(pwr_en), .fault_cmd(fcmd),
        .fault_n(fault_n), .rails_on(rails), .bias_on(bias));

    task finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    task chk_bit(input string name, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_bit

    task chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_word

    task timed_out(input string name);
        chk_bit(name, 1'b1, 1'b0);
        finish_test();
    endtask : timed_out

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clk_sys);
            if (pready === 1'b1)
                break;
        end
        if (i == 20)
            timed_out("apb ready");
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task insert_check(input int s, input logic dual);
        int   t, t_pwr, t_con;
        logic con;
        t_pwr = -1;
        t_con = -1;
        apb(1'b1, `REG_CMD_OFF, 32'h1 << (`CMD_INSERT_LSB + s));
        for (t = 0; t < 200 && rst_n[s] !== 1'b1; t++)
        begin
            @(posedge clk_sys);
            con = dual ? (bus_iso[s] & clk_iso[s]) : ~quiesce;
            if (t_pwr < 0 && pwr_en[s] === 1'b1)
                t_pwr = t;
            if (t_con < 0 && con === 1'b1)
            begin
                t_con = t;
                chk_bit("precharge before close", 1'b1, bias[s]);
            end
            if (!dual && quiesce === 1'b1)
                chk_bit("slot clock in event", 1'b0, slot_clk);
            chk_bit("feedback clock", 1'b1, fbk_clk);
        end
        if (t == 200)
            timed_out("insert done");
        chk_bit("settle before connect", 1'b1, t_pwr >= 0 && t_con >= t_pwr + SETTLE);
        chk_bit("connect before reset", 1'b1, t_con >= 0 && t >= t_con + RUN);
        chk_bit("green lit", 1'b1, green[s]);
        if (dual)
            chk_bit("slot clock gate dual", 1'b1, slot_clk);
        else
            chk_bit("bus switch unused", 1'b0, bus_iso[s]);
    endtask : insert_check

    task remove_check(input int s, input logic dual, input logic by_attn, input logic other);
        int t, t_rst, t_dis;
        t_rst = -1;
        t_dis = -1;
        if (by_attn)
        begin
            @(posedge clk_sys);
            attn[s] <= 1'b1;
            repeat (3) @(posedge clk_sys);
            attn[s] <= 1'b0;
        end
        else
            apb(1'b1, `REG_CMD_OFF, 32'h1 << (`CMD_REMOVE_LSB + s));
        for (t = 0; t < 200 && pwr_en[s] !== 1'b0; t++)
        begin
            @(posedge clk_sys);
            if (t_rst < 0 && rst_n[s] === 1'b0)
                t_rst = t;
            if (t_dis < 0 && (dual ? bus_iso[s] : ~quiesce) === 1'b0)
                t_dis = t;
            chk_bit("other slot reset", other, rst_n[1 - s]);
        end
        if (t == 200)
            timed_out("remove done");
        chk_bit("reset before power off", 1'b1, t_rst >= 0 && t >= t_rst + RUN);
        chk_bit("bus open before power off", 1'b1, t_dis >= t_rst && t >= t_dis + RUN);
    endtask : remove_check

    task test_reset;
        chk_bit("quiesce in reset", 1'b1, quiesce);
        chk_word("outputs in reset", 32'h0, {pwr_en, bus_iso, clk_iso, rst_n});
        repeat (3) @(posedge clk_sys);
        chk_bit("feedback clock", 1'b1, fbk_clk);
        chk_word("aux follows latch", 32'h3, {30'h0, aux});
        apb(1'b0, `REG_CTRL_OFF, 32'h0);
        chk_word("ctrl reset", `CTRL_RESET_VAL, rd);
        apb(1'b1, 12'h010, 32'hffff_ffff);
        chk_bit("unmapped write error", 1'b1, err);
        apb(1'b0, 12'h010, 32'h0);
        chk_bit("unmapped read error", 1'b1, err);
        chk_word("unmapped read data", 32'h0, rd);
        $display("test_reset done");
    endtask : test_reset

    task test_single;
        insert_check(0, 1'b0);
        chk_bit("quiesce released", 1'b0, quiesce);
        chk_bit("slot clock running", 1'b1, slot_clk);
        apb(1'b0, `REG_STATUS_OFF, 32'h0);
        chk_word("status slot on", {24'h0, 4'hc, 4'(ST_ON)}, rd);
        apb(1'b1, `REG_CMD_OFF, 32'h2);
        repeat (12) @(posedge clk_sys);
        chk_bit("slot1 ignored single", 1'b0, pwr_en[1]);
        remove_check(0, 1'b0, 1'b0, 1'b0);
        chk_bit("quiesce after removal", 1'b1, quiesce);
        chk_bit("slot clock after removal", 1'b0, slot_clk);
        $display("test_single done");
    endtask : test_single

    task test_dual;
        apb(1'b1, `REG_CTRL_OFF, 32'h1);
        insert_check(0, 1'b1);
        insert_check(1, 1'b1);
        remove_check(1, 1'b1, 1'b1, 1'b1);
        chk_word("slot1 switches open", 32'h0, {bus_iso[1], clk_iso[1]});
        $display("test_dual done");
    endtask : test_dual

    task test_fault;
        int t;
        @(posedge clk_sys);
        fcmd[0] <= 1'b1;
        for (t = 0; t < 50 && pwr_en[0] !== 1'b0; t++)
            @(posedge clk_sys);
        if (t == 50)
            timed_out("fault response");
        repeat (3) @(posedge clk_sys);
        chk_word("fault shutdown", 32'h0, {rst_n[0], bus_iso[0], clk_iso[0]});
        chk_bit("amber on fault", 1'b1, amber[0]);
        chk_bit("bias off after fault", 1'b0, bias[0]);
        apb(1'b0, `REG_EVENT_OFF, 32'h0);
        chk_word("fault event", 32'h1, rd);
        apb(1'b1, `REG_EVENT_OFF, 32'h1);
        apb(1'b0, `REG_EVENT_OFF, 32'h0);
        chk_word("event cleared", 32'h0, rd);
        fcmd[0]  <= 1'b0;
        latch[0] <= 1'b1;
        repeat (5) @(posedge clk_sys);
        apb(1'b0, `REG_STATUS_OFF, 32'h0);
        chk_word("fault state left", {28'h1, 4'(ST_OFF)}, {20'h0, rd[11:0]});
        $display("test_fault done");
    endtask : test_fault

    task test_aux;
        apb(1'b1, `REG_CTRL_OFF, 32'h3);
        repeat (3) @(posedge clk_sys);
        chk_word("aux blocked", 32'h2, {30'h0, aux});
        latch <= 2'h2;
        repeat (3) @(posedge clk_sys);
        chk_word("aux latch open", 32'h0, {30'h0, aux});
        apb(1'b1, `REG_CTRL_OFF, 32'h1);
        latch <= 2'h0;
        repeat (3) @(posedge clk_sys);
        chk_word("aux restored", 32'h3, {30'h0, aux});
        $display("test_aux done");
    endtask : test_aux

    initial
    begin
        repeat (8) @(posedge clk_sys);
        test_reset_hold();
    end

    task test_reset_hold;
        chk_bit("quiesce held", 1'b1, quiesce);
        reset_n <= 1'b1;
        test_reset();
        test_single();
        test_dual();
        test_fault();
        test_aux();
        finish_test();
    endtask : test_reset_hold
endmodule : test_pci_hotplug_slot_control
